// ==== hdl/swfwd_pkg.sv ====
// Purpose: Constants and types for the switch forwarding lookup engine
// Assumes: Seven switch ports, highest numbered port is the host port
// Notes:   Register offsets are byte addresses of aligned 32-bit words
package swfwd_pkg;
  localparam int NPORT      = 7;
  localparam int PW         = 3;
  localparam int VIDW       = 12;
  localparam int FIDW       = 7;
  localparam int MACW       = 48;
  localparam int VLAN_DEPTH = 4096;
  localparam int DYN_DEPTH  = 1024;
  localparam int DYN_IW     = 10;
  localparam int STAT_DEPTH = 16;
  localparam int STAT_IW    = 4;
  localparam int MC_BIT     = 40;
  localparam logic [2:0] HOST_PORT = 3'h6;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL0      = 8'h00;
  localparam logic [7:0] REG_CTRL2      = 8'h08;
  localparam logic [7:0] REG_UNK_VID    = 8'h0c;
  localparam logic [7:0] REG_VLAN_DATA  = 8'h10;
  localparam logic [7:0] REG_VLAN_CMD   = 8'h14;
  localparam logic [7:0] REG_STAT_MACL  = 8'h18;
  localparam logic [7:0] REG_STAT_MACH  = 8'h1c;
  localparam logic [7:0] REG_STAT_CTL   = 8'h20;
  localparam logic [7:0] REG_STATUS     = 8'h24;
  localparam logic [7:0] REG_LAST_MAP   = 8'h28;
  localparam logic [7:0] REG_ALLOW_BASE = 8'h40;
  localparam logic [7:0] REG_PVID_BASE  = 8'h60;
  localparam logic [7:0] REG_BANK_MASK  = 8'he0;

  // Field positions
  localparam int CTRL0_VLAN_EN_BIT  = 7;
  localparam int CTRL0_DROP_INV_BIT = 6;
  localparam int CTRL2_EGF_HI       = 5;
  localparam int CTRL2_EGF_LO       = 4;
  localparam int UNK_FWD_BIT        = 8;
  localparam int VE_FID_LSB         = 8;
  localparam int VE_FWDOPT_BIT      = 16;
  localparam int VE_VALID_BIT       = 17;
  localparam int VE_W               = 18;
  localparam int SC_PORTS_LSB       = 8;
  localparam int SC_FID_LSB         = 16;
  localparam int SC_VALID_BIT       = 24;
  localparam int DE_PORT_LSB        = 48;
  localparam int DE_FID_LSB         = 51;
  localparam int DE_VALID_BIT       = 58;
  localparam int DE_W               = 59;
  localparam int LM_DROP_BIT        = 8;
  localparam int LM_S1_LSB          = 16;
  localparam int ST_BUSY_BIT        = 31;

  // Reset values
  localparam logic [7:0]      CTRL0_RST  = 8'h40;
  localparam logic [11:0]     PVID_RST   = 12'h001;
  localparam logic [6:0]      ALLOW_RST  = 7'h7f;
  localparam logic [11:0]     VID_ONE    = 12'h001;
  localparam logic [VE_W-1:0] VID1_ENTRY = 18'h2007f;
  localparam logic [11:0]     INIT_LAST  = 12'hfff;

  typedef enum logic [0:0] {
    SWFWD_INIT = 1'b0,
    SWFWD_RUN  = 1'b1
  } swfwd_state_t;
endpackage

// ==== hdl/swfwd_top.sv ====
// Purpose: Forwarding decision of the switch lookup_engine, one map per frame
// Assumes: Parsed headers arrive as a one-cycle strobe; FRM_PORT_I below 7
// Notes:   Three-cycle pipeline; tables cleared by a 4096-cycle sweep at reset
//
// How it works
// - Stage one from VLAN, static, dynamic lookups
// - Spanning tree, snooping, mirroring, port masks refine
// - Access control result overrides, forms final map
// - Error and management frames never forwarded
// - Pause frames consumed, drive flow control
// - Destination equal to ingress port means local
// - Per-ingress allowed egress set masks ports
// - Port mask on except under access control override, resets to all
// - VLAN table of 4k entries kept
// - VLAN mode reads entry by VID first
// - Invalid VID drops unless forwarded, never learned
// - Unknown VID goes to list or host
// - Valid VID gives FID for both lookups
// - Table hit needs matching FID
// - Destination miss floods VLAN members
// - Egress filtering ANDs address and member lists
// - Source miss learns address with FID
// - Untagged or null VID uses port default
// - VLAN table used even when VLAN disabled
// - Default VID 1, entry 1 all members
// - Egress filtering off after reset
// - Control 0 bit 7 enable, bit 6 drop
// - Control 2 bits 5 and 4 filtering
// - VLAN off and miss uses default members
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module swfwd_top (
  input  wire logic        SYS_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  input  wire logic        FRM_VALID_I,
  input  wire logic [2:0]  FRM_PORT_I,
  input  wire logic [47:0] FRM_DA_I,
  input  wire logic [47:0] FRM_SA_I,
  input  wire logic        FRM_TAGGED_I,
  input  wire logic [11:0] FRM_VID_I,
  input  wire logic [3:0]  FRM_ERR_I,
  input  wire logic        FRM_MGMT_I,
  input  wire logic        FRM_PAUSE_I,
  input  wire logic [6:0]  STP_FWD_I,
  input  wire logic [6:0]  SNOOP_MAP_I,
  input  wire logic [6:0]  MIRROR_MAP_I,
  input  wire logic        ACL_OVR_I,
  input  wire logic [6:0]  ACL_MAP_I,
  output logic             READY_O,
  output logic             OUT_VALID_O,
  output logic      [2:0]  OUT_PORT_O,
  output logic      [6:0]  OUT_MAP_O,
  output logic             OUT_DROP_O,
  output logic      [6:0]  PAUSE_O,
  output logic             LEARN_O
);
  localparam int NP = swfwd_pkg::NPORT;

  swfwd_pkg::swfwd_state_t state_r;
  logic [11:0]  init_cnt_r;
  logic [7:0]   ctrl0_r;
  logic [1:0]   egf_r;
  logic [7:0]   unk_list_r;
  logic [17:0]  vlan_data_r;
  logic [47:0]  stat_mac_stage_r;
  logic [15:0]  frm_cnt_r;
  logic [6:0]   allow_r [NP];
  logic [11:0]  pvid_r [NP];
  logic [17:0]  vlan_mem [swfwd_pkg::VLAN_DEPTH];
  logic [58:0]  dyn_mem [swfwd_pkg::DYN_DEPTH];
  logic [47:0]  stat_mac [swfwd_pkg::STAT_DEPTH];
  logic [6:0]   stat_fid [swfwd_pkg::STAT_DEPTH];
  logic [6:0]   stat_map [swfwd_pkg::STAT_DEPTH];
  logic [15:0]  stat_vld;
  logic [15:0]  stat_hit;
  logic         vlan_en, drop_inv, egf, unk_fwd, accept;
  logic [11:0]  vid_eff;
  logic [17:0]  vlan_rd;
  logic         a_vld, a_mgmt, a_pause, a_err, a_acl;
  logic         b_vld, b_mgmt, b_pause, b_err, b_acl;
  logic [2:0]   a_port, b_port;
  logic [47:0]  a_da, a_sa, b_da, b_sa;
  logic [6:0]   a_stp, a_snoop, a_mir, a_aclm, b_stp, b_snoop, b_mir, b_aclm;
  logic [17:0]  b_ve;
  logic [58:0]  dyn_da_rd, dyn_sa_rd;
  logic [9:0]   da_idx, sa_idx, learn_idx;
  logic [6:0]   b_fid, vmem, src_oh, stat_sel, addr_map, allow_sel;
  logic         vvalid, stat_any, dyn_da_hit, dyn_sa_hit, addr_hit;
  logic         local_pkt, drop_any, learn;
  logic [6:0]   stage_one_port_map, stage_two_map, final_port_map;
  logic [6:0]   stage_one_port_map_r;

  assign vlan_en  = ctrl0_r[swfwd_pkg::CTRL0_VLAN_EN_BIT];
  assign drop_inv = ctrl0_r[swfwd_pkg::CTRL0_DROP_INV_BIT];
  // Either filtering bit turns the AND on; both reset low
  assign egf      = |egf_r;
  assign unk_fwd  = unk_list_r[7];
  assign accept   = FRM_VALID_I && (state_r == swfwd_pkg::SWFWD_RUN);

  // Table clear sweep; frames are refused until it ends
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_r    <= swfwd_pkg::SWFWD_INIT;
      init_cnt_r <= 12'h000;
      READY_O    <= 1'b0;
    end else begin
      case (state_r)
        swfwd_pkg::SWFWD_INIT: begin
          init_cnt_r <= init_cnt_r + 12'h001;
          if (init_cnt_r == swfwd_pkg::INIT_LAST) begin
            state_r <= swfwd_pkg::SWFWD_RUN;
            READY_O <= 1'b1;
          end
        end
        swfwd_pkg::SWFWD_RUN: READY_O <= 1'b1;
        default: state_r <= swfwd_pkg::SWFWD_INIT;
      endcase
    end
  end

  // Global control registers
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      ctrl0_r    <= swfwd_pkg::CTRL0_RST;
      egf_r      <= 2'h0;
      unk_list_r <= 8'h00;
      vlan_data_r <= 18'h00000;
      stat_mac_stage_r <= 48'h000000000000;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        swfwd_pkg::REG_CTRL0: ctrl0_r <= REG_WDATA_I[7:0];
        swfwd_pkg::REG_CTRL2:
          egf_r <= REG_WDATA_I[swfwd_pkg::CTRL2_EGF_HI:swfwd_pkg::CTRL2_EGF_LO];
        swfwd_pkg::REG_UNK_VID: unk_list_r <= REG_WDATA_I[7:0]; // Enable rides in bit 7
        swfwd_pkg::REG_VLAN_DATA: vlan_data_r <= REG_WDATA_I[17:0];
        swfwd_pkg::REG_STAT_MACL: stat_mac_stage_r[31:0] <= REG_WDATA_I;
        swfwd_pkg::REG_STAT_MACH: stat_mac_stage_r[47:32] <= REG_WDATA_I[15:0];
        default: ;
      endcase
    end
  end

  // Per-port egress masks and default VIDs
  for (genvar gp = 0; gp < NP; gp++) begin : g_port
    always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
        // all paths open, default VID one
        allow_r[gp] <= swfwd_pkg::ALLOW_RST;
        pvid_r[gp]  <= swfwd_pkg::PVID_RST;
      end else if (REG_WR_I) begin
        if (REG_ADDR_I == swfwd_pkg::REG_ALLOW_BASE + 8'(4 * gp))
          allow_r[gp] <= REG_WDATA_I[6:0];
        if (REG_ADDR_I == swfwd_pkg::REG_PVID_BASE + 8'(4 * gp))
          pvid_r[gp] <= REG_WDATA_I[11:0];
      end
    end
  end

  // Register read, one cycle later; unmapped reads give zero
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      REG_RDATA_O <= 32'h00000000;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= 32'h00000000;
      case (REG_ADDR_I)
        swfwd_pkg::REG_CTRL0:     REG_RDATA_O[7:0] <= ctrl0_r;
        swfwd_pkg::REG_CTRL2:
          REG_RDATA_O[swfwd_pkg::CTRL2_EGF_HI:swfwd_pkg::CTRL2_EGF_LO] <= egf_r;
        swfwd_pkg::REG_UNK_VID:   REG_RDATA_O[8:0] <= {1'b0, unk_list_r};
        swfwd_pkg::REG_VLAN_DATA: REG_RDATA_O[17:0] <= vlan_data_r;
        swfwd_pkg::REG_STAT_MACL: REG_RDATA_O <= stat_mac_stage_r[31:0];
        swfwd_pkg::REG_STAT_MACH: REG_RDATA_O[15:0] <= stat_mac_stage_r[47:32];
        swfwd_pkg::REG_STATUS:
          REG_RDATA_O <= {state_r == swfwd_pkg::SWFWD_INIT, 15'h0000, frm_cnt_r};
        swfwd_pkg::REG_LAST_MAP:
          REG_RDATA_O[22:0] <= {stage_one_port_map_r, 7'h00, OUT_DROP_O, 1'b0, OUT_MAP_O};
        default: begin
          if (REG_ADDR_I[4:2] < 3'(NP)) begin
            if ((REG_ADDR_I & swfwd_pkg::REG_BANK_MASK) == swfwd_pkg::REG_ALLOW_BASE)
              REG_RDATA_O[6:0] <= allow_r[REG_ADDR_I[4:2]];
            if ((REG_ADDR_I & swfwd_pkg::REG_BANK_MASK) == swfwd_pkg::REG_PVID_BASE)
              REG_RDATA_O[11:0] <= pvid_r[REG_ADDR_I[4:2]];
          end
        end
      endcase
    end
  end

  // untagged or null VID takes port default
  // default VID also read with VLAN off
  assign vid_eff = (vlan_en && FRM_TAGGED_I && (FRM_VID_I != 12'h000)) ? FRM_VID_I
                                                                      : pvid_r[FRM_PORT_I];

  // 4k-entry table; entry one seeded with all members
  always_ff @(posedge SYS_CLK_I) begin
    if (state_r == swfwd_pkg::SWFWD_INIT)
      vlan_mem[init_cnt_r] <= (init_cnt_r == swfwd_pkg::VID_ONE) ? swfwd_pkg::VID1_ENTRY
                                                                 : 18'h00000;
    else if (REG_WR_I && REG_ADDR_I == swfwd_pkg::REG_VLAN_CMD)
      vlan_mem[REG_WDATA_I[11:0]] <= vlan_data_r;
  end

  // entry read by VID at frame accept
  always_ff @(posedge SYS_CLK_I) begin
    vlan_rd <= vlan_mem[vid_eff];
  end

  // Stage A capture of header and parallel side inputs
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      a_vld <= 1'b0;
    end else begin
      a_vld <= accept;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    a_port  <= FRM_PORT_I;
    a_da    <= FRM_DA_I;
    a_sa    <= FRM_SA_I;
    a_err   <= |FRM_ERR_I;
    a_mgmt  <= FRM_MGMT_I;
    a_pause <= FRM_PAUSE_I;
    a_stp   <= STP_FWD_I;
    a_snoop <= SNOOP_MAP_I;
    a_mir   <= MIRROR_MAP_I;
    a_acl   <= ACL_OVR_I;
    a_aclm  <= ACL_MAP_I;
  end

  // FID added to the low 10 DA and SA bits
  assign da_idx = a_da[9:0] + {3'h0, vlan_rd[swfwd_pkg::VE_FID_LSB +: 7]};
  assign sa_idx = a_sa[9:0] + {3'h0, vlan_rd[swfwd_pkg::VE_FID_LSB +: 7]};

  // Stage B: entry and both address reads land together
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      b_vld <= 1'b0;
    end else begin
      b_vld <= a_vld;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    b_port    <= a_port;
    b_da      <= a_da;
    b_sa      <= a_sa;
    b_err     <= a_err;
    b_mgmt    <= a_mgmt;
    b_pause   <= a_pause;
    b_stp     <= a_stp;
    b_snoop   <= a_snoop;
    b_mir     <= a_mir;
    b_acl     <= a_acl;
    b_aclm    <= a_aclm;
    b_ve      <= vlan_rd;
    dyn_da_rd <= dyn_mem[da_idx];
    dyn_sa_rd <= dyn_mem[sa_idx];
    learn_idx <= sa_idx;
  end

  // Static table, written by software through staging registers
  for (genvar gs = 0; gs < swfwd_pkg::STAT_DEPTH; gs++) begin : g_stat
    always_ff @(posedge SYS_CLK_I) begin
      if (!NRST_I) begin
        stat_vld[gs] <= 1'b0;
      end else if (REG_WR_I && REG_ADDR_I == swfwd_pkg::REG_STAT_CTL &&
                   REG_WDATA_I[3:0] == 4'(gs)) begin
        stat_vld[gs] <= REG_WDATA_I[swfwd_pkg::SC_VALID_BIT];
        stat_mac[gs] <= stat_mac_stage_r;
        stat_fid[gs] <= REG_WDATA_I[swfwd_pkg::SC_FID_LSB +: 7];
        stat_map[gs] <= REG_WDATA_I[swfwd_pkg::SC_PORTS_LSB +: 7];
      end
    end
    assign stat_hit[gs] = stat_vld[gs] && stat_mac[gs] == b_da && stat_fid[gs] == b_fid;
  end

  assign b_fid     = b_ve[swfwd_pkg::VE_FID_LSB +: 7];
  assign vmem      = b_ve[6:0];
  assign vvalid    = b_ve[swfwd_pkg::VE_VALID_BIT];
  assign src_oh    = 7'h01 << b_port;
  assign allow_sel = allow_r[b_port];
  assign stat_any  = |stat_hit;
  // dynamic hits need FID match too
  assign dyn_da_hit = dyn_da_rd[swfwd_pkg::DE_VALID_BIT] && dyn_da_rd[47:0] == b_da &&
                      dyn_da_rd[swfwd_pkg::DE_FID_LSB +: 7] == b_fid;
  assign dyn_sa_hit = dyn_sa_rd[swfwd_pkg::DE_VALID_BIT] && dyn_sa_rd[47:0] == b_sa &&
                      dyn_sa_rd[swfwd_pkg::DE_FID_LSB +: 7] == b_fid;
  assign addr_hit   = stat_any || dyn_da_hit;

  // Lowest static index wins; static beats dynamic
  always_comb begin
    stat_sel = 7'h00;
    for (int i = swfwd_pkg::STAT_DEPTH - 1; i >= 0; i--) begin
      if (stat_hit[i])
        stat_sel = stat_map[i];
    end
    addr_map = stat_any ? stat_sel : (7'h01 << dyn_da_rd[swfwd_pkg::DE_PORT_LSB +: 3]);
  end

  // Stage one decision
  always_comb begin
    if (!vlan_en)
      // miss with VLAN off floods default members
      stage_one_port_map = addr_hit ? addr_map : vmem;
    else if (!vvalid)
      // unknown VID list, else drop or host
      stage_one_port_map = unk_fwd ? unk_list_r[6:0]
                                   : (drop_inv ? 7'h00 : (7'h01 << swfwd_pkg::HOST_PORT));
    else if (b_ve[swfwd_pkg::VE_FWDOPT_BIT] || !addr_hit)
      stage_one_port_map = vmem;
    else if (egf)
      stage_one_port_map = addr_map & vmem;
    else
      stage_one_port_map = addr_map;
  end

  // Stage two refinement, access control on top
  always_comb begin
    // destination equal to source is local
    local_pkt = addr_hit && (addr_map == src_oh);
    drop_any  = b_err || b_mgmt || b_pause || local_pkt;
    stage_two_map = stage_one_port_map & b_stp & ~src_oh;
    if (b_da[swfwd_pkg::MC_BIT])
      stage_two_map = stage_two_map & b_snoop;
    // ingress egress mask, applied in every mode except the access control override
    stage_two_map = (stage_two_map | b_mir) & allow_sel;
    final_port_map = b_acl ? b_aclm : stage_two_map;
    if (drop_any)
      final_port_map = 7'h00;
  end

  // learn or migrate on source miss; never for invalid VID in VLAN mode
  assign learn = b_vld && !b_err && !b_sa[swfwd_pkg::MC_BIT] && !(vlan_en && !vvalid) &&
                 (!dyn_sa_hit || dyn_sa_rd[swfwd_pkg::DE_PORT_LSB +: 3] != b_port);

  // Dynamic table: sweep clear, then learning writes
  always_ff @(posedge SYS_CLK_I) begin
    if (state_r == swfwd_pkg::SWFWD_INIT)
      dyn_mem[init_cnt_r[9:0]] <= 59'h0;
    else if (learn)
      dyn_mem[learn_idx] <= {1'b1, b_fid, b_port, b_sa};
  end

  // Result registers; drop flagged and an empty map handed over
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      OUT_VALID_O <= 1'b0;
      OUT_PORT_O  <= 3'h0;
      OUT_MAP_O   <= 7'h00;
      OUT_DROP_O  <= 1'b0;
      PAUSE_O     <= 7'h00;
      LEARN_O     <= 1'b0;
      stage_one_port_map_r <= 7'h00;
      frm_cnt_r   <= 16'h0000;
    end else begin
      // one final map per accepted frame
      OUT_VALID_O <= b_vld;
      LEARN_O     <= learn;
      // flow control pulse on receiving port
      PAUSE_O     <= (b_vld && b_pause) ? src_oh : 7'h00;
      if (b_vld) begin
        OUT_PORT_O  <= b_port;
        OUT_MAP_O   <= final_port_map;
        OUT_DROP_O  <= drop_any || (final_port_map == 7'h00);
        stage_one_port_map_r <= stage_one_port_map;
        frm_cnt_r   <= frm_cnt_r + 16'h0001;
      end
    end
  end

  AST_ONE_MAP: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    accept |-> ##3 OUT_VALID_O)
    else $error("accepted frame gave no result");

  AST_ERR_DROP: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (accept && (|FRM_ERR_I || FRM_MGMT_I)) |-> ##3 (OUT_DROP_O && OUT_MAP_O == 7'h00))
    else $error("error or management frame forwarded");

  AST_PAUSE: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (accept && FRM_PAUSE_I) |-> ##3 (OUT_MAP_O == 7'h00 &&
                                    PAUSE_O == (7'h01 << $past(FRM_PORT_I, 3))))
    else $error("pause frame not consumed");

  AST_LOCAL: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (b_vld && addr_hit && addr_map == src_oh) |=> (OUT_DROP_O && OUT_MAP_O == 7'h00))
    else $error("local frame forwarded");

  AST_RESTRICT: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (b_vld && !b_acl) |=> ((OUT_MAP_O & ~$past(allow_sel)) == 7'h00))
    else $error("frame sent to disallowed egress port");

  AST_ACL: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (b_vld && b_acl && !drop_any) |=> (OUT_MAP_O == $past(b_aclm)))
    else $error("access control map not applied");

  AST_INV_VID: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (b_vld && vlan_en && !vvalid && !unk_fwd && drop_inv) |=> (OUT_MAP_O == 7'h00 && !LEARN_O))
    else $error("invalid VID frame forwarded or learned");

  AST_MISS_FLOOD: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (b_vld && vlan_en && vvalid && !addr_hit) |=> (stage_one_port_map_r == $past(vmem)))
    else $error("miss did not flood VLAN members");

  AST_EGF: assert property (
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (b_vld && vlan_en && vvalid && addr_hit && egf && !b_ve[swfwd_pkg::VE_FWDOPT_BIT])
      |=> (stage_one_port_map_r == $past(addr_map & vmem)))
    else $error("egress filtering not applied");
endmodule
`default_nettype wire

// ==== test/swfwd_egress_model.sv ====
// Purpose: Egress queue stand-in that records each forwarding result
// Assumes: Results arrive as one-cycle valid pulses with pause and learn
// Notes:   Pulses are kept until the next result so the bench reads late
`timescale 1ns/1ps
`default_nettype none
module swfwd_egress_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        valid_i,
  input  wire logic [6:0]  map_i,
  input  wire logic        drop_i,
  input  wire logic [6:0]  pause_i,
  input  wire logic        learn_i,
  output logic      [15:0] cnt_o,
  output logic      [6:0]  map_o,
  output logic             drop_o,
  output logic      [6:0]  pause_o,
  output logic             learn_o
);
  // Queue accepts only on the pulse; counting exposes doubled results
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_o <= 16'h0000;
    end else if (valid_i) begin
      cnt_o   <= cnt_o + 16'h0001;
      map_o   <= map_i;
      drop_o  <= drop_i;
      pause_o <= pause_i;
      learn_o <= learn_i;
    end
  end
endmodule
`default_nettype wire

// ==== test/swfwd_top_tb.sv ====
// Purpose: Self-checking bench for the forwarding decision block
// Assumes: Tables need the full clear sweep before frames are sent
// Notes:   Frames are spaced out, so learned entries are never stale
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED t=%0t got %0h want %0h", $time, a, e); end end
module swfwd_top_tb;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, fv = 1'b0;
  logic        tg = 1'b0, mg = 1'b0, pz = 1'b0, ao = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [2:0]  fp = 3'h0, oport;
  logic [47:0] da = 48'h0, sa = 48'h0;
  logic [11:0] vid = 12'h000;
  logic [3:0]  er = 4'h0;
  logic [6:0]  stp = 7'h7f, snp = 7'h7f, mir = 7'h00, am = 7'h00;
  logic        rdy, ov, odrop, lrn, mdrop, lrn_m;
  logic [6:0]  omap, pse, mmap, pse_m;
  logic [15:0] cnt;
  int          n_errors = 0, total_checks = 0;

  // Free-running 25 MHz core clock
  initial forever #20 clk = ~clk;

  swfwd_top swfwd_top_i (.SYS_CLK_I(clk), .NRST_I(nrst), .REG_ADDR_I(adr), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .FRM_VALID_I(fv), .FRM_PORT_I(fp),
    .FRM_DA_I(da), .FRM_SA_I(sa), .FRM_TAGGED_I(tg), .FRM_VID_I(vid), .FRM_ERR_I(er),
    .FRM_MGMT_I(mg), .FRM_PAUSE_I(pz), .STP_FWD_I(stp), .SNOOP_MAP_I(snp),
    .MIRROR_MAP_I(mir), .ACL_OVR_I(ao), .ACL_MAP_I(am), .READY_O(rdy), .OUT_VALID_O(ov),
    .OUT_PORT_O(oport), .OUT_MAP_O(omap), .OUT_DROP_O(odrop), .PAUSE_O(pse),
    .LEARN_O(lrn));

  swfwd_egress_model swfwd_egress_model_i (.clk_i(clk), .nrst_i(nrst), .valid_i(ov),
    .map_i(omap), .drop_i(odrop), .pause_i(pse), .learn_i(lrn), .cnt_o(cnt),
    .map_o(mmap), .drop_o(mdrop), .pause_o(pse_m), .learn_o(lrn_m));

  // Single-cycle write strobe
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin adr <= a; wd <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask

  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin adr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 `CHK(rdat, e)
  endtask

  // One frame; source address is unique per ingress port
  task automatic frm(input logic [2:0] p, input logic [47:0] d, input logic [6:0] em,
                     input logic ed);
    logic [15:0] c;
    int          k;
    c = cnt;
    @(posedge clk) begin fp <= p; da <= d; sa <= {37'h0, p, 8'h22}; fv <= 1'b1; end
    @(posedge clk) fv <= 1'b0;
    for (k = 0; k < 8 && cnt == c; k++) @(posedge clk);
    #1 `CHK(cnt, c + 16'h0001)
    `CHK(mdrop, ed)
    `CHK(oport, p)
    `CHK(mmap, em)
    // Trailing cycles catch a second result for the same frame
    repeat (3) @(posedge clk);
    `CHK(cnt, c + 16'h0001)
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog at 7000 cycles: the 4096-cycle clear sweep plus about 2900 more
  initial begin
    repeat (7000) @(posedge clk);
    n_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    int k;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rreg(swfwd_pkg::REG_CTRL0, 32'h0000_0040);
    rreg(swfwd_pkg::REG_ALLOW_BASE, 32'h0000_007f);
    rreg(swfwd_pkg::REG_PVID_BASE, 32'h0000_0001);
    rreg(8'hfc, 32'h0000_0000);
    for (k = 0; k < 5000 && rdy !== 1'b1; k++) @(posedge clk);
    `CHK(rdy, 1'b1)
    $display("test registers done");
    frm(3'h0, 48'h111, 7'h7e, 1'b0);
    `CHK(lrn_m, 1'b1)
    frm(3'h2, 48'h022, 7'h01, 1'b0);
    frm(3'h0, 48'h022, 7'h00, 1'b1);
    @(posedge clk) er <= 4'h2;
    frm(3'h1, 48'h111, 7'h00, 1'b1);
    @(posedge clk) begin er <= 4'h0; mg <= 1'b1; end
    frm(3'h1, 48'h111, 7'h00, 1'b1);
    @(posedge clk) begin mg <= 1'b0; pz <= 1'b1; end
    frm(3'h3, 48'h111, 7'h00, 1'b1);
    `CHK(pse_m, 7'h08)
    $display("test drops done");
    @(posedge clk) begin pz <= 1'b0; ao <= 1'b1; am <= 7'h30; end
    frm(3'h0, 48'h111, 7'h30, 1'b0);
    @(posedge clk) begin ao <= 1'b0; stp <= 7'h0f; end
    frm(3'h0, 48'h111, 7'h0e, 1'b0);
    @(posedge clk) begin stp <= 7'h7f; snp <= 7'h06; end
    frm(3'h0, 48'h0100_0000_0044, 7'h06, 1'b0);
    @(posedge clk) begin snp <= 7'h7f; mir <= 7'h40; end
    frm(3'h2, 48'h022, 7'h41, 1'b0);
    @(posedge clk) mir <= 7'h00;
    wreg(swfwd_pkg::REG_ALLOW_BASE + 8'h04, 32'h0000_000d);
    frm(3'h1, 48'h111, 7'h0d, 1'b0);
    $display("test refinement done");
    wreg(swfwd_pkg::REG_CTRL0, 32'h0000_00c0);
    @(posedge clk) begin tg <= 1'b1; vid <= 12'h005; end
    frm(3'h0, 48'h111, 7'h00, 1'b1);
    wreg(swfwd_pkg::REG_UNK_VID, 32'h0000_008c);
    rreg(swfwd_pkg::REG_UNK_VID, 32'h0000_008c);
    frm(3'h0, 48'h111, 7'h0c, 1'b0);
    @(posedge clk) vid <= 12'h000;
    wreg(swfwd_pkg::REG_VLAN_DATA, 32'h0002_0006);
    wreg(swfwd_pkg::REG_VLAN_CMD, 32'h0000_0001);
    frm(3'h2, 48'h022, 7'h01, 1'b0);
    frm(3'h2, 48'h111, 7'h02, 1'b0);
    wreg(swfwd_pkg::REG_STAT_MACL, 32'h0000_0333);
    wreg(swfwd_pkg::REG_STAT_CTL, 32'h0100_1000);
    frm(3'h2, 48'h333, 7'h10, 1'b0);
    wreg(swfwd_pkg::REG_STAT_MACL, 32'h0000_0444);
    wreg(swfwd_pkg::REG_STAT_CTL, 32'h0101_2001);
    frm(3'h2, 48'h444, 7'h02, 1'b0);
    wreg(swfwd_pkg::REG_CTRL2, 32'h0000_0030);
    rreg(swfwd_pkg::REG_CTRL2, 32'h0000_0030);
    frm(3'h2, 48'h022, 7'h00, 1'b1);
    $display("test vlan done");
    test_done();
  end
endmodule
`default_nettype wire
